//--- bench/mcsr_amp_model.sv
/*
  amplifier side model: link presence per axis and axis motion levels.
  assumes hot-swap orders and the stop level come from the bank on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module mcsr_amp_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] plugged,
  input  wire logic [31:0] run_req,
  input  wire logic        hotswap_exec,
  input  wire logic        hotswap_reconnect,
  input  wire logic [5:0]  hotswap_axis,
  input  wire logic        stop_all_axes,
  output logic      [31:0] amp_comm_ok,
  output logic      [31:0] axis_running
);
  logic [31:0] cut_reg;
  logic [31:0] run_reg;
  // a cut link stays silent until a reconnect is executed
  always_ff @(posedge clk) begin
    if (reset)
      cut_reg <= '0;
    else if (hotswap_exec && hotswap_reconnect)
      cut_reg <= '0;
    else if (hotswap_exec)
      cut_reg[5'(hotswap_axis - 6'h01)] <= 1'b1;
  end
  // axes only move with a live link, and halt on the stop level
  always_ff @(posedge clk) begin
    if (reset || stop_all_axes)
      run_reg <= '0;
    else
      run_reg <= run_req & amp_comm_ok;
  end
  assign amp_comm_ok  = plugged & ~cut_reg;
  assign axis_running = run_reg;
endmodule
`default_nettype wire

//--- bench/tb_top.sv
/*
  self-checking bench of the status register bank, full and 8-axis builds.
  assumes the amplifier model beside it and a 125 mhz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top
  import mcsr_pkg::*;
;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic [4:0]    reg_addr = '0;
  logic [15:0]   reg_wdata = '0;
  logic          reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0]   reg_rdata, rdata_small;
  logic [31:0]   plugged = '1, run_req = '0, cut_exp = '0, used = '1;
  logic [31:0]   amp_comm_ok, axis_running;
  logic          test_request = 1'b0, prog_err = 1'b0, link_err = 1'b0;
  logic          program_start_instruction = 1'b0, program_done = 1'b0;
  logic          link_ok = 1'b0;
  mcsr_wdt_evt_t wdt_evt = '0;
  logic [11:0]   prog_err_num = '0;
  logic [2:0]    link_err_code = '0;
  logic          hotswap_exec, hotswap_reconnect, stop_all_axes;
  logic [5:0]    hotswap_axis;
  logic          start_blocked, test_request_error_flag, irq;
  logic          program_setting_error_flag;
  logic [15:0]   t = 16'h002a, ax, exp_w;
  logic [15:0]   wexp [5] = '{16'd2, 16'd3, 16'd4, 16'd30, 16'd300};
  int            fails = 0, cmp_count = 0;

  mcsr_core #(.AXES(32)) i_dut (.*);
  mcsr_core #(.AXES(8)) i_small (.*, .reg_rdata(rdata_small),
    .hotswap_exec(), .hotswap_reconnect(), .hotswap_axis(),
    .stop_all_axes(), .start_blocked(), .test_request_error_flag(),
    .program_setting_error_flag(), .irq());
  mcsr_amp_model i_amp (.*);

  always #4 clk = ~clk;

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected presence: used, plugged and not cut by a hot-swap
  function automatic logic [31:0] pres();
    return plugged & used & ~cut_exp;
  endfunction

  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic rd_pres();
    logic [31:0] p;
    step(3);
    p = pres();
    rd(OFS_PRESENT_LO, p[15:0]);
    `CHK(rdata_small, {8'h00, p[7:0]})
    rd(OFS_PRESENT_HI, p[31:16]);
    `CHK(rdata_small, 16'h0000)
  endtask
  task automatic hs_run(logic [15:0] req);
    int n;
    wr(OFS_HOTSWAP, req);
    rd(OFS_HOTSWAP, HS_PENDING);
    wr(OFS_HOTSWAP, 16'h0003);
    wr(OFS_HOTSWAP, HS_EXECUTE);
    // the pulse is launched at this edge; look once it has settled
    #1;
    for (n = 0; n < 20 && hotswap_exec !== 1'b1; n++)
      @(posedge clk) #1;
    if (n == 20) begin
      fails++;
      give_verdict();
    end
    `CHK(hotswap_reconnect, (req == HS_RECONNECT))
    if (req != HS_RECONNECT) `CHK(hotswap_axis, req[5:0])
    rd(OFS_HOTSWAP, HS_IDLE);
  endtask
  task automatic hard_reset();
    @(posedge clk);
    reset <= 1'b1;
    step(2);
    reset <= 1'b0;
  endtask
  task automatic wdt_pulse(mcsr_wdt_evt_t e);
    @(posedge clk);
    wdt_evt <= e;
    @(posedge clk);
    wdt_evt <= '0;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    give_verdict();
  end

  initial begin
    step(20);
    reset <= 1'b0;
    rd(OFS_HOTSWAP, HS_IDLE);
    rd(OFS_LINK_ERR, LINK_OK);
    rd(5'h1f, 16'h0000);
    // execute with nothing pending must do nothing
    wr(OFS_HOTSWAP, HS_EXECUTE);
    rd(OFS_HOTSWAP, HS_IDLE);
    `CHK(hotswap_exec, 1'b0)
    for (int i = 0; i < 3; i++) begin
      t = lfsr(t);
      ax = (i == 0) ? 16'd32 : {11'h000, t[4:0]} + 16'd1;
      hs_run(ax);
      cut_exp[ax - 16'd1] = 1'b1;
      rd_pres();
    end
    hs_run(HS_RECONNECT);
    cut_exp = '0;
    rd_pres();
    for (int i = 0; i < 3; i++) begin
      t = lfsr(t);
      used = {t, lfsr(t)};
      t = lfsr(lfsr(t));
      plugged <= {lfsr(t), t};
      wr(OFS_AXIS_USED_LO, used[15:0]);
      wr(OFS_AXIS_USED_HI, used[31:16]);
      rd_pres();
    end
    plugged <= '1;
    used = '1;
    wr(OFS_AXIS_USED_LO, 16'hffff);
    wr(OFS_AXIS_USED_HI, 16'hffff);
    t = lfsr(t);
    run_req <= {t, lfsr(t)} | 32'h8000_0001;
    step(3);
    @(posedge clk) test_request <= 1'b1;
    @(posedge clk) test_request <= 1'b0;
    step(2);
    `CHK(test_request_error_flag, 1'b1)
    rd(OFS_TEST_LO, run_req[15:0]);
    `CHK(rdata_small, {8'h00, run_req[7:0]})
    rd(OFS_TEST_HI, run_req[31:16]);
    `CHK(rdata_small, 16'h0000)
    wr(OFS_FLAGS, 16'h0001);
    run_req <= '0;
    step(3);
    @(posedge clk) test_request <= 1'b1;
    @(posedge clk) test_request <= 1'b0;
    step(2);
    `CHK(test_request_error_flag, 1'b0)
    for (int i = 0; i < 3; i++) begin
      t = lfsr(t);
      @(posedge clk);
      prog_err <= 1'b1;
      prog_err_num <= (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : t[11:0];
      @(posedge clk) prog_err <= 1'b0;
      rd(OFS_FAIL_PROG, {4'h0, prog_err_num});
      `CHK(program_setting_error_flag, 1'b1)
    end
    for (int c = 1; c < 6; c++) begin
      @(posedge clk);
      link_err <= 1'b1;
      link_err_code <= 3'(c);
      @(posedge clk) link_err <= 1'b0;
      rd(OFS_LINK_ERR, 16'(c));
    end
    @(posedge clk) link_ok <= 1'b1;
    @(posedge clk) link_ok <= 1'b0;
    rd(OFS_LINK_ERR, LINK_OK);
    // interrupt: masked, unmasked, then cleared by writing one
    wr(OFS_IRQ_MASK, 16'h0000);
    wr(OFS_IRQ_STATUS, 16'h001f);
    @(posedge clk) link_err <= 1'b1;
    @(posedge clk) link_err <= 1'b0;
    step(2);
    `CHK(irq, 1'b0)
    rd(OFS_IRQ_STATUS, 16'h0008);
    wr(OFS_IRQ_MASK, 16'h0008);
    #1 `CHK(irq, 1'b1)
    wr(OFS_IRQ_STATUS, 16'h0008);
    #1 `CHK(irq, 1'b0)
    for (int k = 0; k < 5; k++) begin
      hard_reset();
      wdt_pulse('{fault: 1'b1, kind: mcsr_wdt_kind_t'(k), default: '0});
      rd(OFS_WDT_CAUSE, wexp[k]);
    end
    for (int k = 0; k < 6; k++) begin
      hard_reset();
      t = lfsr(t);
      run_req <= '1;
      step(3);
      if (k < 2) begin
        exp_w = (k == 0) ? 16'd15 : {12'h000, t[3:0] | 4'h1};
        wdt_pulse('{fault: 1'b1, kind: mcsr_wdt_cycle_over, bus_hw: 1'b1,
                    bus_bits: exp_w[3:0], default: '0});
        exp_w = 16'd200 + exp_w;
      end else begin
        wdt_pulse('{fault: 1'b1, kind: mcsr_wdt_cycle_over, amp_hw: 1'b1,
                    amp_line: 2'(k - 2), default: '0});
        exp_w = 16'd248 + 16'(k);
      end
      rd(OFS_WDT_CAUSE, exp_w);
      step(2);
      `CHK(stop_all_axes, 1'b1)
      `CHK(start_blocked, 1'b1)
      `CHK(axis_running, 32'h0000_0000)
      @(posedge clk) program_start_instruction <= 1'b1;
      @(posedge clk) program_start_instruction <= 1'b0;
      rd(OFS_WDT_CAUSE, exp_w);
    end
    run_req <= '0;
    hard_reset();
    for (int k = 0; k < 15; k++) begin
      if (k == 14) rd(OFS_WDT_CAUSE, WDT_NONE);
      @(posedge clk) program_start_instruction <= 1'b1;
      @(posedge clk) program_start_instruction <= 1'b0;
    end
    rd(OFS_WDT_CAUSE, 16'd301);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- design/mcsr_axis_map.sv
/*
  per-axis bitmap splitter: one 32-axis vector into low and high words,
  axes above the variant limit forced to zero.
  assumes axis n sits at vector bit n-1.
*/
`timescale 1ns/1ns
`default_nettype none
module mcsr_axis_map
  import mcsr_pkg::*;
#(
  parameter int AXES = 32
) (
  input  wire logic [31:0] axis_vec,
  output logic      [15:0] word_lo,
  output logic      [15:0] word_hi
);
  if (AXES < 1 || AXES > 32) begin : g_bad_axes
    $error("AXES must be 1..32");
  end

  logic [31:0] masked;
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_ax
      // higher axes carry nothing on smaller variants
      assign masked[g] = (g < AXES) ? axis_vec[g] : 1'b0;
    end
  endgenerate

  assign word_lo = masked[15:0];
  assign word_hi = masked[31:16];
endmodule
`default_nettype wire

//--- design/mcsr_core.sv
/*
  motion cpu status register bank: hot-swap handshake, test-mode error
  bitmaps, watchdog cause, failing program, amplifier presence, link
  error and an interrupt block, all behind a plain register port.
  assumes event inputs are single-cycle pulses from logic on clk and that
  amplifier/axis levels come from the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module mcsr_core
  import mcsr_pkg::*;
#(
  parameter int AXES = 32
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic [4:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  input  wire logic [31:0]   axis_running,
  input  wire logic          test_request,
  input  wire mcsr_wdt_evt_t wdt_evt,
  input  wire logic          program_start_instruction,
  input  wire logic          program_done,
  input  wire logic          prog_err,
  input  wire logic [11:0]   prog_err_num,
  input  wire logic [31:0]   amp_comm_ok,
  input  wire logic          link_err,
  input  wire logic [2:0]    link_err_code,
  input  wire logic          link_ok,
  output logic               hotswap_exec,
  output logic               hotswap_reconnect,
  output logic      [5:0]    hotswap_axis,
  output logic               stop_all_axes,
  output logic               start_blocked,
  output logic               test_request_error_flag,
  output logic               program_setting_error_flag,
  output logic               irq
);
  if (AXES < 1 || AXES > 32) begin : g_bad_axes
    $error("AXES must be 1..32");
  end

  typedef enum logic [1:0] {
    mcsr_hs_idle,
    mcsr_hs_pending,
    mcsr_hs_execute
  } mcsr_hs_state_t;

  mcsr_hs_state_t hs_state_reg, hs_state_next;
  logic [15:0] hs_cmd_reg;
  logic [31:0] test_map_reg;
  logic [15:0] wdt_cause_reg;
  logic        hw_stop_reg;
  logic [11:0] fail_prog_reg;
  logic [31:0] present_reg;
  logic [31:0] axis_used_reg;
  logic [15:0] link_err_reg;
  logic [4:0]  active_progs_reg;
  logic        test_flag_reg;
  logic        prog_flag_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [15:0] rdata_reg;
  logic        exec_pulse_reg;

  // address decode
  wire wr_hs     = reg_wr && reg_addr == OFS_HOTSWAP;
  wire wr_status = reg_wr && reg_addr == OFS_IRQ_STATUS;
  wire wr_mask   = reg_wr && reg_addr == OFS_IRQ_MASK;
  wire wr_flags  = reg_wr && reg_addr == OFS_FLAGS;
  wire wr_used_lo = reg_wr && reg_addr == OFS_AXIS_USED_LO;
  wire wr_used_hi = reg_wr && reg_addr == OFS_AXIS_USED_HI;

  // handshake command classes
  wire cmd_disc  = $signed(reg_wdata) >= $signed(HS_AXIS_MIN) &&
                   $signed(reg_wdata) <= $signed(HS_AXIS_MAX);
  wire cmd_recon = reg_wdata == HS_RECONNECT;
  wire cmd_exec  = reg_wdata == HS_EXECUTE;

  always_comb begin
    hs_state_next = hs_state_reg;
    case (hs_state_reg)
      mcsr_hs_idle: begin
        if (wr_hs && (cmd_disc || cmd_recon)) begin
          hs_state_next = mcsr_hs_pending;
        end
      end
      mcsr_hs_pending: begin
        if (wr_hs && cmd_exec) begin
          hs_state_next = mcsr_hs_execute;
        end
      end
      default: hs_state_next = mcsr_hs_idle;
    endcase
  end

  // visible handshake word
  wire [15:0] hs_word = (hs_state_reg == mcsr_hs_idle) ? HS_IDLE
                                                       : HS_PENDING;

  always_ff @(posedge clk) begin
    if (reset) begin
      hs_state_reg   <= mcsr_hs_idle;
      hs_cmd_reg     <= HS_IDLE;
      exec_pulse_reg <= 1'b0;
    end else begin
      hs_state_reg   <= hs_state_next;
      exec_pulse_reg <= hs_state_next == mcsr_hs_execute;
      if (hs_state_reg == mcsr_hs_idle && wr_hs && (cmd_disc || cmd_recon)) begin
        hs_cmd_reg <= reg_wdata;
      end
    end
  end

  assign hotswap_exec      = exec_pulse_reg;
  assign hotswap_reconnect = hs_cmd_reg == HS_RECONNECT;
  assign hotswap_axis      = hs_cmd_reg[5:0];

  // test mode request error
  wire test_err = test_request && (|axis_running);
  always_ff @(posedge clk) begin
    if (reset) begin
      test_map_reg  <= 32'h0000_0000;
      test_flag_reg <= 1'b0;
    end else begin
      if (test_err) begin
        test_map_reg  <= axis_running;
        test_flag_reg <= 1'b1;
      end else if (wr_flags && reg_wdata[0]) begin
        test_flag_reg <= 1'b0;
      end
    end
  end

  // watchdog cause
  logic        wdt_hw;
  logic [15:0] wdt_code;
  mcsr_wdt_coder u_wdt (
    .clk      (clk),
    .evt      (wdt_evt),
    .hw_fault (wdt_hw),
    .code     (wdt_code)
  );

  // a start over the limit is refused and reported, never queued; the
  // counter only tracks programs that were really launched
  wire start_ok   = program_start_instruction && !hw_stop_reg;
  wire start_over = start_ok && active_progs_reg >= START_LIMIT;

  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_cause_reg    <= WDT_NONE;
      hw_stop_reg      <= 1'b0;
      active_progs_reg <= 5'h00;
    end else begin
      if (wdt_evt.fault || wdt_hw) begin
        wdt_cause_reg <= wdt_code;
      end else if (start_over) begin
        wdt_cause_reg <= WDT_START_OVER;
      end
      if (wdt_hw) begin
        hw_stop_reg <= 1'b1;
      end
      if (start_ok && !start_over && !program_done) begin
        active_progs_reg <= active_progs_reg + 5'h01;
      end else if (program_done && !start_ok && active_progs_reg != 5'h00) begin
        active_progs_reg <= active_progs_reg - 5'h01;
      end
    end
  end

  assign stop_all_axes = hw_stop_reg;
  assign start_blocked = hw_stop_reg;

  // failing program number, newest wins
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_prog_reg <= 12'h000;
      prog_flag_reg <= 1'b0;
    end else begin
      if (prog_err) begin
        fail_prog_reg <= prog_err_num;
        prog_flag_reg <= 1'b1;
      end else if (wr_flags && reg_wdata[1]) begin
        prog_flag_reg <= 1'b0;
      end
    end
  end

  // amplifier presence: reset clears, then re-checked every cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      present_reg   <= 32'h0000_0000;
      axis_used_reg <= 32'hffff_ffff;
    end else begin
      present_reg <= axis_used_reg & amp_comm_ok;
      if (wr_used_lo) begin
        axis_used_reg[15:0] <= reg_wdata;
      end
      if (wr_used_hi) begin
        axis_used_reg[31:16] <= reg_wdata;
      end
    end
  end

  // pc link error code
  always_ff @(posedge clk) begin
    if (reset) begin
      link_err_reg <= LINK_OK;
    end else if (link_err) begin
      link_err_reg <= {13'h0000, link_err_code};
    end else if (link_ok) begin
      link_err_reg <= LINK_OK;
    end
  end

  // interrupts: sticky events, write one to clear, set beats clear
  wire [IRQ_W-1:0] irq_evt = {exec_pulse_reg, link_err,
                              wdt_evt.fault | wdt_hw | start_over,
                              prog_err, test_err};
  wire [IRQ_W-1:0] irq_clr = wr_status ? reg_wdata[IRQ_W-1:0]
                                       : {IRQ_W{1'b0}};
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status_reg <= {IRQ_W{1'b0}};
      irq_mask_reg   <= {IRQ_W{1'b0}};
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_evt;
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // bitmaps limited to the variant's axes
  logic [15:0] test_lo, test_hi, pres_lo, pres_hi;
  mcsr_axis_map #(.AXES(AXES)) u_test_map (
    .axis_vec (test_map_reg),
    .word_lo  (test_lo),
    .word_hi  (test_hi)
  );
  mcsr_axis_map #(.AXES(AXES)) u_pres_map (
    .axis_vec (present_reg),
    .word_lo  (pres_lo),
    .word_hi  (pres_hi)
  );

  // read mux; unmapped reads as zero
  logic [15:0] rd_mux;
  always_comb begin
    if (reg_addr == OFS_HOTSWAP) rd_mux = hs_word;
    else if (reg_addr == OFS_TEST_LO) rd_mux = test_lo;
    else if (reg_addr == OFS_TEST_HI) rd_mux = test_hi;
    else if (reg_addr == OFS_WDT_CAUSE) rd_mux = wdt_cause_reg;
    else if (reg_addr == OFS_FAIL_PROG) rd_mux = {4'h0, fail_prog_reg};
    else if (reg_addr == OFS_PRESENT_LO) rd_mux = pres_lo;
    else if (reg_addr == OFS_PRESENT_HI) rd_mux = pres_hi;
    else if (reg_addr == OFS_LINK_ERR) rd_mux = link_err_reg;
    else if (reg_addr == OFS_IRQ_STATUS) rd_mux = {11'h000, irq_status_reg};
    else if (reg_addr == OFS_IRQ_MASK) rd_mux = {11'h000, irq_mask_reg};
    else if (reg_addr == OFS_FLAGS) rd_mux = {14'h0000, prog_flag_reg,
                                              test_flag_reg};
    else if (reg_addr == OFS_AXIS_USED_LO) rd_mux = axis_used_reg[15:0];
    else if (reg_addr == OFS_AXIS_USED_HI) rd_mux = axis_used_reg[31:16];
    else rd_mux = 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign reg_rdata                  = rdata_reg;
  assign test_request_error_flag    = test_flag_reg;
  assign program_setting_error_flag = prog_flag_reg;

  chk_hs_pending_word: assert property (@(posedge clk) disable iff (reset)
    hs_state_reg == mcsr_hs_idle && wr_hs && (cmd_disc || cmd_recon)
    |=> hs_word == HS_PENDING) else $error("handshake not pending");
  chk_hs_idle_after: assert property (@(posedge clk) disable iff (reset)
    hs_state_reg == mcsr_hs_execute |=> hs_word == HS_IDLE)
    else $error("handshake not idle after execute");
  chk_test_flag_clear: assert property (@(posedge clk) disable iff (reset)
    wr_flags && reg_wdata[0] && !test_err |=> !test_flag_reg)
    else $error("test error flag not cleared");
  chk_hw_start_refused: assert property (@(posedge clk) disable iff (reset)
    hw_stop_reg && program_start_instruction && !program_done
    |=> active_progs_reg == $past(active_progs_reg))
    else $error("start accepted after hardware stop");
  chk_present_unused: assert property (@(posedge clk) disable iff (reset)
    !axis_used_reg[0] |=> !present_reg[0])
    else $error("unused axis shown as installed");
  chk_test_capture: assert property (@(posedge clk) disable iff (reset)
    test_err |=> test_flag_reg && test_map_reg == $past(axis_running))
    else $error("test error capture wrong");
  chk_hw_stop_holds: assert property (@(posedge clk) disable iff (reset)
    wdt_hw |=> stop_all_axes [*8])
    else $error("hardware stop not held");
  chk_start_over: assert property (@(posedge clk) disable iff (reset)
    start_over && !wdt_evt.fault && !wdt_hw |=> wdt_cause_reg == 16'd301)
    else $error("start overflow code missing");
  chk_prog_newest: assert property (@(posedge clk) disable iff (reset)
    prog_err |=> fail_prog_reg == $past(prog_err_num) && prog_flag_reg)
    else $error("failing program not stored");
  chk_present_track: assert property (@(posedge clk) disable iff (reset)
    !amp_comm_ok[0] |=> !present_reg[0])
    else $error("presence bit not cleared");
  chk_link_resume: assert property (@(posedge clk) disable iff (reset)
    link_ok && !link_err |=> link_err_reg == 16'h0000)
    else $error("link error not cleared");
  chk_link_store: assert property (@(posedge clk) disable iff (reset)
    link_err |=> link_err_reg == {13'h0000, $past(link_err_code)})
    else $error("link error code not stored");
endmodule
`default_nettype wire

//--- design/mcsr_pkg.sv
/*
  package of the motion cpu status register bank: word offsets, codes,
  reset values and event/control encodings.
  assumes a single 125 mhz clock and 16-bit register words.
*/
package mcsr_pkg;

  // register word offsets
  localparam logic [4:0] OFS_HOTSWAP     = 5'h00;
  localparam logic [4:0] OFS_TEST_LO     = 5'h01;
  localparam logic [4:0] OFS_TEST_HI     = 5'h02;
  localparam logic [4:0] OFS_WDT_CAUSE   = 5'h03;
  localparam logic [4:0] OFS_FAIL_PROG   = 5'h04;
  localparam logic [4:0] OFS_PRESENT_LO  = 5'h05;
  localparam logic [4:0] OFS_PRESENT_HI  = 5'h06;
  localparam logic [4:0] OFS_LINK_ERR    = 5'h07;
  localparam logic [4:0] OFS_IRQ_STATUS  = 5'h08;
  localparam logic [4:0] OFS_IRQ_MASK    = 5'h09;
  localparam logic [4:0] OFS_FLAGS       = 5'h0a;
  localparam logic [4:0] OFS_AXIS_USED_LO = 5'h0b;
  localparam logic [4:0] OFS_AXIS_USED_HI = 5'h0c;

  // handshake word values (two's complement)
  localparam logic [15:0] HS_IDLE      = 16'h0000;
  localparam logic [15:0] HS_PENDING   = 16'hffff;
  localparam logic [15:0] HS_EXECUTE   = 16'hfffe;
  localparam logic [15:0] HS_RECONNECT = 16'hfff6;
  localparam logic [15:0] HS_AXIS_MIN  = 16'h0001;
  localparam logic [15:0] HS_AXIS_MAX  = 16'h0020;

  // watchdog cause codes
  localparam logic [15:0] WDT_NONE       = 16'h0000;
  localparam logic [15:0] WDT_CYCLE_OVER = 16'h0002;
  localparam logic [15:0] WDT_BUS_WDT    = 16'h0003;
  localparam logic [15:0] WDT_GENERAL    = 16'h0004;
  localparam logic [15:0] WDT_PROC_HW    = 16'h001e;
  localparam logic [15:0] WDT_BUS_HW     = 16'h00c8;
  localparam logic [15:0] WDT_AMP_HW     = 16'h00fa;
  localparam logic [15:0] WDT_SW3        = 16'h012c;
  localparam logic [15:0] WDT_START_OVER = 16'h012d;
  localparam logic [4:0]  START_LIMIT    = 5'h0e;

  // link error codes
  localparam logic [15:0] LINK_OK = 16'h0000;

  // program number field width
  localparam int PROG_W = 12;

  // interrupt status bits
  localparam int IRQ_TEST_ERR = 0;
  localparam int IRQ_PROG_ERR = 1;
  localparam int IRQ_WDT      = 2;
  localparam int IRQ_LINK     = 3;
  localparam int IRQ_HOTSWAP  = 4;
  localparam int IRQ_W        = 5;

  // simple watchdog fault kinds reported by the core
  typedef enum logic [2:0] {
    mcsr_wdt_cycle_over,
    mcsr_wdt_bus_wdt,
    mcsr_wdt_general,
    mcsr_wdt_proc_hw,
    mcsr_wdt_sw3
  } mcsr_wdt_kind_t;

  typedef struct packed {
    logic           fault;
    mcsr_wdt_kind_t kind;
    logic           bus_hw;
    logic [3:0]     bus_bits;
    logic           amp_hw;
    logic [1:0]     amp_line;
  } mcsr_wdt_evt_t;

  typedef struct packed {
    logic [4:0]        addr;
    logic [15:0]       wdata;
    logic              wr;
    logic              rd;
  } mcsr_bus_req_t;

endpackage

//--- design/mcsr_wdt_coder.sv
/*
  watchdog cause encoder: turns a fault event into its cause code.
  assumes the event is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module mcsr_wdt_coder
  import mcsr_pkg::*;
(
  input  wire logic          clk,
  input  wire mcsr_wdt_evt_t evt,
  output logic               hw_fault,
  output logic [15:0]        code
);
  wire [15:0] bus_code = WDT_BUS_HW + {12'h000, evt.bus_bits};
  wire [15:0] amp_code = WDT_AMP_HW + {14'h0000, evt.amp_line};
  logic [15:0] kind_code;

  always_comb begin
    case (evt.kind)
      mcsr_wdt_cycle_over: kind_code = WDT_CYCLE_OVER;
      mcsr_wdt_bus_wdt:    kind_code = WDT_BUS_WDT;
      mcsr_wdt_general:    kind_code = WDT_GENERAL;
      mcsr_wdt_proc_hw:    kind_code = WDT_PROC_HW;
      default:             kind_code = WDT_SW3;
    endcase
  end

  // hardware faults take precedence over a software kind in the same cycle
  assign code = evt.bus_hw ? bus_code : (evt.amp_hw ? amp_code : kind_code);
  assign hw_fault = evt.bus_hw | evt.amp_hw;

  chk_bus_code_range: assert property (@(posedge clk)
    evt.bus_hw && evt.bus_bits != 4'h0 |-> code >= 16'd201 && code <= 16'd215)
    else $error("bus fault code out of range");
  chk_amp_code_range: assert property (@(posedge clk)
    !evt.bus_hw && evt.amp_hw |-> code >= 16'd250 && code <= 16'd253)
    else $error("amp fault code out of range");
endmodule
`default_nettype wire
